// ### inc/field_event_pkg.sv
// constants for the field event configuration and detection block
// assumes one 100 MHz clock and a register port of 8-bit address, 32-bit data
package field_event_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] field_event_config_off = 8'h03;
    localparam logic [7:0] user_storage_word_a_off = 8'h0d;
    localparam logic [7:0] user_storage_word_b_off = 8'h0e;
    localparam logic [7:0] user_storage_word_c_off = 8'h0f;
    localparam logic [7:0] event_status_off = 8'h28;
    localparam logic [7:0] write_status_off = 8'h29;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int signed_sel_bit = 24;
    localparam int delta_mode_bit = 23;
    localparam int persist_flag_bit = 22;
    localparam int persist_write_en_bit = 21;
    localparam int z_enable_bit = 20;
    localparam int y_enable_bit = 19;
    localparam int x_enable_bit = 18;
    localparam int z_thresh_lsb = 12;
    localparam int y_thresh_lsb = 6;
    localparam int x_thresh_lsb = 0;
    localparam int thresh_width = 6;
    localparam int user_width = 26;
    localparam int event_status_bit = 6;
    localparam int write_busy_bit = 20;
    localparam int config_used_width = 25;

    // ---------------------------------------------------------------
    // reset values and timing
    // ---------------------------------------------------------------
    localparam logic [31:0] config_reset = 32'h0000_0000;
    localparam logic [25:0] user_reset = 26'h000_0000;
    localparam int clk_mhz = 100;
    localparam int nv_write_time_us = 10;
    localparam int nv_write_cycles = nv_write_time_us * clk_mhz;

endpackage

// ### rtl/nv_flag_writer.sv
// timed programming sequence for the persistent event flag
// assumes a synchronous active-high reset and a single-cycle start request
`timescale 1ns/1ps
`default_nettype none

module nv_flag_writer (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    output logic busy,
    output logic done
);

    typedef enum logic [0:0] {
        idle_s = 1'b0,
        prog_s = 1'b1
    } writer_state_t;

    writer_state_t state_reg;
    logic [15:0] count_reg;

    // ---------------------------------------------------------------
    // programming timer
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= idle_s;
            count_reg <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_reg)
                idle_s: begin
                    if (start) begin
                        state_reg <= prog_s;
                        count_reg <= 16'(field_event_pkg::nv_write_cycles - 1);
                    end
                end
                prog_s: begin
                    if (count_reg == 16'h0000) begin
                        state_reg <= idle_s;
                        done <= 1'b1;
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                default: state_reg <= idle_s;
            endcase
        end
    end

    assign busy = (state_reg == prog_s);

endmodule

`default_nettype wire

// ### rtl/field_event_config.sv
// event configuration, threshold and delta detection for a three-axis field sensor
// assumes samples arrive as signed 12-bit words with a one-cycle valid pulse,
// and the register port is a simple synchronous read/write port
`timescale 1ns/1ps
`default_nettype none

// How it works
// (RULE1) config bit 24 picks absolute (0) or signed (1) threshold meaning.
// (RULE2) absolute mode fires when an enabled axis exceeds the threshold in either direction.
// (RULE3) signed mode fires only when the field passes the signed threshold in its own direction.
// (RULE4) with bit 23 clear each newest sample is compared directly.
// (RULE5) with bit 23 set the first sample in duty-cycled low-power mode is the reference for a difference.
// (RULE6) a persistent event flag (bit 22) records that an event happened; reset clears it like every other config bit.
// (RULE7) with the persistent write enable set an event programs that flag, otherwise not.
// (RULE8) per-axis enables for Z, Y and X; a disabled axis never fires.
// (RULE9) each axis has a 6-bit threshold at bits 17:12, 11:6 and 5:0.
// (RULE10) three 26-bit user storage words affect nothing.
// (RULE11) every event field resets to zero so detection starts disabled.
// (RULE12) with hold enabled the status bit and output stay set after the event ends.
// (RULE13) writing 1 to the held status bit releases status and output.
// (RULE14) a busy bit reads 1 while the persistent flag is being programmed and clears itself.
// (RULE15) the event is the OR of the enabled axis conditions, once per sample.
module field_event_config (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic hold_enable,
    input wire logic duty_cycled_low_power_mode,
    input wire logic sample_valid,
    input wire logic signed [11:0] sample_x,
    input wire logic signed [11:0] sample_y,
    input wire logic signed [11:0] sample_z,
    output logic event_out,
    output logic nv_write_busy
);

    logic [31:0] config_reg;
    logic [25:0] user_a_reg;
    logic [25:0] user_b_reg;
    logic [25:0] user_c_reg;
    logic [31:0] config_next;
    logic signed [11:0] ref_x_reg;
    logic signed [11:0] ref_y_reg;
    logic signed [11:0] ref_z_reg;
    logic ref_taken_reg;
    logic status_reg;
    logic event_now;
    logic hit_x;
    logic hit_y;
    logic hit_z;
    logic writer_busy;
    logic writer_done;
    logic writer_start;
    logic clear_hit;

    // ---------------------------------------------------------------
    // per-axis comparison
    // ---------------------------------------------------------------
    function automatic logic axis_hit(
        input logic signed [11:0] value,
        input logic signed [11:0] reference,
        input logic [5:0] thresh,
        input logic use_delta,
        input logic signed_mode
    );
        logic signed [12:0] diff;
        logic signed [12:0] mag;
        logic signed [12:0] t_abs;
        logic signed [12:0] t_sgn;
        diff = use_delta ? (13'(value) - 13'(reference)) : 13'(value); // [RULE4] [RULE5]
        mag = diff[12] ? -diff : diff;
        t_abs = {7'h00, thresh};
        t_sgn = {{7{thresh[5]}}, thresh};
        if (signed_mode) begin
            // negative threshold fires below it, positive above it
            axis_hit = thresh[5] ? (diff < t_sgn) : (diff > t_sgn); // [RULE3]
        end else begin
            axis_hit = mag > t_abs; // [RULE2]
        end
    endfunction

    always_comb begin
        hit_x = config_reg[field_event_pkg::x_enable_bit] && axis_hit(sample_x, ref_x_reg, // [RULE8]
            config_reg[field_event_pkg::x_thresh_lsb +: field_event_pkg::thresh_width], // [RULE9]
            config_reg[field_event_pkg::delta_mode_bit], config_reg[field_event_pkg::signed_sel_bit]); // [RULE1]
        hit_y = config_reg[field_event_pkg::y_enable_bit] && axis_hit(sample_y, ref_y_reg, // [RULE8]
            config_reg[field_event_pkg::y_thresh_lsb +: field_event_pkg::thresh_width], // [RULE9]
            config_reg[field_event_pkg::delta_mode_bit], config_reg[field_event_pkg::signed_sel_bit]);
        hit_z = config_reg[field_event_pkg::z_enable_bit] && axis_hit(sample_z, ref_z_reg, // [RULE8]
            config_reg[field_event_pkg::z_thresh_lsb +: field_event_pkg::thresh_width], // [RULE9]
            config_reg[field_event_pkg::delta_mode_bit], config_reg[field_event_pkg::signed_sel_bit]);
        // delta mode waits until a reference exists
        event_now = sample_valid && (hit_x || hit_y || hit_z) && // [RULE15]
            (!config_reg[field_event_pkg::delta_mode_bit] || ref_taken_reg);
    end

    // ---------------------------------------------------------------
    // delta reference capture
    // ---------------------------------------------------------------
    // leaving low-power mode drops the reference so re-entry takes a fresh one
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_taken_reg <= 1'b0;
            ref_x_reg <= 12'sh000;
            ref_y_reg <= 12'sh000;
            ref_z_reg <= 12'sh000;
        end else if (!duty_cycled_low_power_mode) begin
            ref_taken_reg <= 1'b0;
        end else if (sample_valid && !ref_taken_reg) begin
            ref_taken_reg <= 1'b1; // [RULE5]
            ref_x_reg <= sample_x;
            ref_y_reg <= sample_y;
            ref_z_reg <= sample_z;
        end
    end

    // ---------------------------------------------------------------
    // event status and hold
    // ---------------------------------------------------------------
    assign clear_hit = reg_write && (reg_addr == field_event_pkg::event_status_off)
        && reg_wdata[field_event_pkg::event_status_bit];

    // without hold each sample rewrites the status; with hold only a clear write drops it
    always_ff @(posedge clk) begin
        if (reset) begin
            status_reg <= 1'b0;
        end else if (event_now) begin
            status_reg <= 1'b1; // set wins over a same-cycle clear
        end else if (hold_enable) begin // [RULE12]
            if (clear_hit) begin
                status_reg <= 1'b0; // [RULE13]
            end
        end else if (sample_valid) begin
            status_reg <= 1'b0;
        end
    end

    assign event_out = status_reg;

    // ---------------------------------------------------------------
    // persistent flag programming
    // ---------------------------------------------------------------
    // an event while the flag is set or a write is running starts nothing
    assign writer_start = event_now && config_reg[field_event_pkg::persist_write_en_bit] // [RULE7]
        && !writer_busy && !config_reg[field_event_pkg::persist_flag_bit];

    nv_flag_writer u_writer (
        .clk(clk),
        .reset(reset),
        .start(writer_start),
        .busy(writer_busy),
        .done(writer_done)
    );

    assign nv_write_busy = writer_busy; // [RULE14]

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    // bits 31:25 are never stored; a finished flag write beats a same-cycle host write
    always_comb begin
        config_next = config_reg;
        if (reg_write && reg_addr == field_event_pkg::field_event_config_off) begin
            config_next = {7'h00, reg_wdata[field_event_pkg::config_used_width-1:0]};
        end
        if (writer_done) begin
            config_next[field_event_pkg::persist_flag_bit] = 1'b1; // [RULE6]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            config_reg <= field_event_pkg::config_reset; // [RULE11]
        end else begin
            config_reg <= config_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            user_a_reg <= field_event_pkg::user_reset;
            user_b_reg <= field_event_pkg::user_reset;
            user_c_reg <= field_event_pkg::user_reset;
        end else if (reg_write) begin
            case (reg_addr)
                field_event_pkg::user_storage_word_a_off: user_a_reg <= reg_wdata[25:0]; // [RULE10]
                field_event_pkg::user_storage_word_b_off: user_b_reg <= reg_wdata[25:0];
                field_event_pkg::user_storage_word_c_off: user_c_reg <= reg_wdata[25:0];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    // the two status words carry only the event bit and the busy bit
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                field_event_pkg::field_event_config_off: reg_rdata <= config_reg;
                field_event_pkg::user_storage_word_a_off: reg_rdata <= {6'h00, user_a_reg};
                field_event_pkg::user_storage_word_b_off: reg_rdata <= {6'h00, user_b_reg};
                field_event_pkg::user_storage_word_c_off: reg_rdata <= {6'h00, user_c_reg};
                field_event_pkg::event_status_off: reg_rdata <= {25'h000_0000, status_reg, 6'h00};
                field_event_pkg::write_status_off: reg_rdata <= {11'h000, writer_busy, 20'h0_0000};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

`default_nettype wire

// ### testbench/field_event_checker.sv
// assertions on the ports of the field event block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module field_event_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic hold_enable,
    input wire logic sample_valid,
    input wire logic event_out,
    input wire logic nv_write_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    localparam int busy_cycles = field_event_pkg::nv_write_cycles;
    logic [10:0] busy_cnt;
    logic clr_wr;
    assign clr_wr = reg_write && reg_addr == 8'h28 && reg_wdata[6];
    // cycles the busy flag has stood so far
    always_ff @(posedge clk) begin
        if (reset || !nv_write_busy)
            busy_cnt <= 11'h000;
        else
            busy_cnt <= busy_cnt + 11'h001;
    end
    reset_clears_a: assert property (disable iff (1'b0) reset |=> !event_out && !nv_write_busy)
        else $error("outputs not cleared by reset");
    cfg_top_zero_a: assert property (reg_read && reg_addr == 8'h03 |=> reg_rdata[31:25] == 7'h00)
        else $error("config top bits not zero");
    busy_from_event_a: assert property ($rose(nv_write_busy) |-> event_out)
        else $error("busy without event");
    busy_length_a: assert property ($fell(nv_write_busy) |-> busy_cnt == busy_cycles)
        else $error("busy length wrong");
    busy_bounded_a: assert property (nv_write_busy |-> busy_cnt < busy_cycles)
        else $error("busy too long");
    rise_on_sample_a: assert property ($rose(event_out) |-> $past(sample_valid))
        else $error("event rose without sample");
    hold_keeps_a: assert property (hold_enable && event_out && !clr_wr |=> event_out)
        else $error("held event dropped");
    hold_clear_a: assert property (hold_enable && event_out && clr_wr && !sample_valid |=> !event_out)
        else $error("held event not released");
    fall_on_sample_a: assert property ($fell(event_out) && !$past(hold_enable) |-> $past(sample_valid))
        else $error("event fell without sample");
    cover property ($rose(nv_write_busy));
    cover property (hold_enable && event_out && clr_wr);
    cover property ($rose(event_out));
endmodule
bind field_event_config field_event_checker chk (.*);
`default_nettype wire

// ### testbench/host_port_model.sv
// host register master model for the field event block
// assumes requests are launched on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_write,
    output logic reg_read,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 32'h0000_0000;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk);
        reg_read = 1'b0;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the field event block
// assumes the host model drives the register port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {
        logic [31:0] cfg;
        logic signed [11:0] x, y, z;
        logic ev;
    } row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hold_enable = 1'b0;
    logic duty_cycled_low_power_mode = 1'b0;
    logic sample_valid = 1'b0;
    logic signed [11:0] sample_x = 12'h000, sample_y = 12'h000, sample_z = 12'h000;
    logic [7:0] reg_addr;
    logic reg_write, reg_read, event_out, nv_write_busy;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [7:0] addrs[6] = '{8'h03, 8'h0d, 8'h0e, 8'h0f, 8'h28, 8'h29};
    int fails = 0;
    int comparisons = 0;
    int n;
    row_t rows[12] = '{
        '{32'h0000_0000, 12'h064, 12'h064, 12'h064, 1'b0}, '{32'h0004_000A, 12'h00B, 12'h064, 12'h064, 1'b1},
        '{32'h0004_000A, 12'h00A, 12'h000, 12'h000, 1'b0}, '{32'h0004_000A, 12'hFF5, 12'h000, 12'h000, 1'b1},
        '{32'h0008_0280, 12'h000, 12'hFF5, 12'h000, 1'b1}, '{32'h0010_A000, 12'h000, 12'h000, 12'h00B, 1'b1},
        '{32'h0010_A000, 12'h032, 12'h032, 12'h000, 1'b0}, '{32'h0104_000A, 12'h00B, 12'h000, 12'h000, 1'b1},
        '{32'h0104_000A, 12'hFF5, 12'h000, 12'h000, 1'b0}, '{32'h0104_0036, 12'hFF5, 12'h000, 12'h000, 1'b1},
        '{32'h0104_0036, 12'h00B, 12'h000, 12'h000, 1'b0}, '{32'h001C_A28A, 12'h000, 12'h000, 12'h00B, 1'b1}};
    always #5 clk = ~clk;
    host_port_model host (.*);
    field_event_config uut (.*);
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(negedge clk);
        {sample_x, sample_y, sample_z, sample_valid} = {x, y, z, 1'b1};
        @(negedge clk);
        {sample_x, sample_y, sample_z, sample_valid} = {~x, ~y, ~z, 1'b0};
    endtask
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        chk("event after reset", 1'b0, event_out);
        foreach (addrs[i]) begin
            host.rd(addrs[i], rv);
            chk("reset value", 32'h0000_0000, rv);
        end
        for (int i = 1; i < 4; i++) begin
            host.wr(addrs[i], 32'hFFFF_FFFF);
            host.rd(addrs[i], rv);
            chk("user word", 32'h03FF_FFFF, rv);
        end
        host.rd(8'h10, rv);
        chk("unmapped read", 32'h0000_0000, rv);
        $display("reset and storage test done");
        foreach (rows[i]) begin
            host.wr(8'h03, rows[i].cfg);
            host.rd(8'h03, rv);
            chk("config word", rows[i].cfg, rv);
            smp(rows[i].x, rows[i].y, rows[i].z);
            chk("event output", rows[i].ev, event_out);
        end
        chk("write busy idle", 1'b0, nv_write_busy);
        $display("table test done");
        hold_enable = 1'b1;
        host.wr(8'h03, 32'h0004_000A);
        smp(12'h014, 12'h000, 12'h000);
        smp(12'h000, 12'h000, 12'h000);
        chk("held event", 1'b1, event_out);
        host.rd(8'h28, rv);
        chk("held status", 1'b1, rv[6]);
        host.wr(8'h28, 32'h0000_0040);
        chk("released event", 1'b0, event_out);
        hold_enable = 1'b0;
        $display("hold test done");
        host.wr(8'h03, 32'h0084_000A);
        duty_cycled_low_power_mode = 1'b1;
        smp(12'h1F4, 12'h000, 12'h000);
        chk("delta reference", 1'b0, event_out);
        smp(12'h1F9, 12'h000, 12'h000);
        chk("delta small", 1'b0, event_out);
        smp(12'h208, 12'h000, 12'h000);
        chk("delta large", 1'b1, event_out);
        duty_cycled_low_power_mode = 1'b0;
        $display("delta test done");
        host.wr(8'h03, 32'h0024_000A);
        smp(12'h014, 12'h000, 12'h000);
        chk("write busy start", 1'b1, nv_write_busy);
        host.rd(8'h29, rv);
        chk("write busy bit", 1'b1, rv[20]);
        n = 0;
        while (nv_write_busy === 1'b1 && n < 1100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 1100)
            fails++;
        // the busy-bit read above used two of the programming cycles
        chk("write busy cycles", field_event_pkg::nv_write_cycles - 2, n);
        host.rd(8'h29, rv);
        chk("write busy done", 1'b0, rv[20]);
        host.rd(8'h03, rv);
        chk("persistent flag", 1'b1, rv[22]);
        smp(12'h014, 12'h000, 12'h000);
        chk("no second write", 1'b0, nv_write_busy);
        $display("persistent flag test done");
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk("event after mid reset", 1'b0, event_out);
        chk("busy after mid reset", 1'b0, nv_write_busy);
        host.rd(8'h28, rv);
        chk("status after mid reset", 32'h0000_0000, rv);
        $display("mid-run reset test done");
        stop_test();
    end
endmodule
`default_nettype wire
